/* File: core/wdt_map.svh */
// Address map, codes, field positions, reset values and counts of the watchdog.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ============================================================
// Register addresses in the CPU register space
`define WD_ADDR_CTRL 12'hFF0
`define WD_ADDR_UPPER 12'hFF1
`define WD_ADDR_HIGH 12'hFF2
`define WD_ADDR_LOW 12'hFF3

// ============================================================
// Unlock codes written to the control address
`define WD_UNLOCK_FIRST 8'h55
`define WD_UNLOCK_SECOND 8'hAA

// ============================================================
// Reload register reset values
`define WD_RST_UPPER 8'h00
`define WD_RST_HIGH 8'h04
`define WD_RST_LOW 8'h00

// ============================================================
// Reset status register fields
`define WD_STAT_TIMEOUT_BIT 7
`define WD_STAT_STOP_BIT 6
`define WD_READ_IDLE 8'h00

// ============================================================
// Counter values
`define WD_CNT_ZERO 24'h000000
`define WD_CNT_ONE 24'h000001
`define WD_CNT_NO_REFRESH 24'h000002
`define WD_CNT_MIN_RELOAD 24'h000004
`define WD_CNT_WRAP 24'hFFFFFF

// ============================================================
// Timing
`define WD_OSC_HZ 10000
`define WD_MS_DIVISOR 10
`define WD_SYS_CLK_HZ 40000000

`endif

/* File: core/wdt_pkg.sv */
// Types shared by the watchdog modules.
`default_nettype none
`include "wdt_map.svh"

package wdt_pkg;

    // One access of the CPU register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Non-volatile option bits.
    typedef struct packed {
        logic always_on_option_bit;
        logic timeout_response_option_bit;
    } option_bits_t;

    // Reload write strobes.
    typedef struct packed {
        logic upper;
        logic high;
        logic low;
    } reload_wr_t;

    typedef enum logic [2:0] {
        LOCK_IDLE = 3'b000,
        LOCK_GOT_FIRST = 3'b001,
        LOCK_WAIT_UPPER = 3'b010,
        LOCK_WAIT_HIGH = 3'b011,
        LOCK_WAIT_LOW = 3'b100
    } lock_state_t;

endpackage : wdt_pkg

`default_nettype wire

/* File: core/wdt_osc_sync.sv */
// Synchroniser and rising edge detector for the RC oscillator input.
`default_nettype none

module wdt_osc_sync (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic osc_in,
    output logic tick
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    logic tick_ff;

    // Only sync_ff reads meta_ff; edges are found on the settled copy.
    // The chain resets high, so a pin that is already high at reset
    // release is not taken for a rising edge.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
            tick_ff <= 1'b0;
        end else begin
            meta_ff <= osc_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            tick_ff <= sync_ff & ~last_ff;
        end
    end

    assign tick = tick_ff;

endmodule : wdt_osc_sync

`default_nettype wire

/* File: core/wdt_unlock_fsm.sv */
// Lock state machine guarding the three reload byte registers.
`default_nettype none

module wdt_unlock_fsm
    import wdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire wdt_pkg::reg_req_t req,
    output wdt_pkg::reload_wr_t reload_wr
);
    lock_state_t state_ff;
    lock_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        reload_wr = '0;
        if (req.wr) begin
            nxt_state = LOCK_IDLE;
            unique case (state_ff)
                LOCK_GOT_FIRST: begin
                    if (req.addr == `WD_ADDR_CTRL &&
                        req.wdata == `WD_UNLOCK_SECOND) begin
                        nxt_state = LOCK_WAIT_UPPER;
                    end
                end
                LOCK_WAIT_UPPER: begin
                    if (req.addr == `WD_ADDR_UPPER) begin
                        reload_wr.upper = 1'b1;
                        nxt_state = LOCK_WAIT_HIGH;
                    end
                end
                LOCK_WAIT_HIGH: begin
                    if (req.addr == `WD_ADDR_HIGH) begin
                        reload_wr.high = 1'b1;
                        nxt_state = LOCK_WAIT_LOW;
                    end
                end
                LOCK_WAIT_LOW: begin
                    if (req.addr == `WD_ADDR_LOW) begin
                        reload_wr.low = 1'b1;
                    end
                end
                LOCK_IDLE: begin
                end
                default: begin
                end
            endcase
            // A fresh first code restarts the sequence from any state.
            if (req.addr == `WD_ADDR_CTRL &&
                req.wdata == `WD_UNLOCK_FIRST) begin
                nxt_state = LOCK_GOT_FIRST;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= LOCK_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule : wdt_unlock_fsm

`default_nettype wire

/* File: core/watchdog_timer_24bit.sv */
// Watchdog timer: 24-bit down counter, reload lock and time-out response.
//
// Behaviour
// - 24-bit reloadable down counter stepped by the dedicated RC oscillator.
// - Reload value is upper, high, low byte, most significant first.
// - Starts on the refresh instruction, or right after reset if always-on.
// - Only on and off; once on, software cannot stop the counter.
// - First enable loads the counter from reload, then counts toward zero.
// - Each refresh instruction reloads the counter; counting then resumes.
// - From count 000002H down to time-out, refreshes are ignored.
// - Time-out in ms is reload value over ten at 10 kHz.
// - Time-out is signalled when the counter reaches 000000H.
// - Response option bit selects interrupt or system reset on time-out.
// - Interrupt response, normal: raise interrupt request, set time-out flag.
// - After interrupt time-out no reload; counter wraps to maximum, counts on.
// - Reading reset status clears time-out flag; software reads it first.
// - Interrupt response in stop: recovery, interrupt, time-out and stop flags.
// - Reset response, normal: force system reset, set time-out flag.
// - Reset response in stop: recovery, set time-out and stop flags.
// - In on-chip debug mode the counter is refreshed continuously.
// - Reload writes only after 55H, AAH, then upper, high, low bytes.
// - Any other write mid-sequence relocks and refuses reload writes.
// - Unlock writes change no control register bits.
// - Control address FF0H is write-only; reads return reset status.
// - Reload byte reads return current count bytes; writes set reload.
`default_nettype none

module watchdog_timer_24bit
    import wdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wdt_osc,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic watchdog_refresh_instruction,
    input wire logic always_on_option_bit,
    input wire logic timeout_response_option_bit,
    input wire logic stop_mode,
    input wire logic on_chip_debugger,
    output logic wdt_irq_req,
    output logic wdt_sys_reset_req,
    output logic wdt_stop_recovery,
    output logic wdt_enabled,
    output logic [23:0] wdt_count
);

    // ============================================================
    // Bundled inputs

    reg_req_t req;
    option_bits_t opts;
    reload_wr_t reload_wr;
    logic osc_tick;

    assign req.wr = reg_wr;
    assign req.rd = reg_rd;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;

    assign opts.always_on_option_bit = always_on_option_bit;
    assign opts.timeout_response_option_bit = timeout_response_option_bit;

    // ============================================================
    // Oscillator crossing

    // The oscillator is far slower than sys_clk, so each of its rising
    // edges becomes exactly one tick.
    // An edge that coincides with reset release may be missed, which
    // costs at most one oscillator period of the first time-out.
    wdt_osc_sync u_osc_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .osc_in(wdt_osc),
        .tick(osc_tick)
    );

    // ============================================================
    // Reload lock

    wdt_unlock_fsm u_unlock (
        .sys_clk(sys_clk),
        .reset(reset),
        .req(req),
        .reload_wr(reload_wr)
    );

    // ============================================================
    // Reload registers

    logic [7:0] reload_upper_byte_ff;
    logic [7:0] reload_high_byte_ff;
    logic [7:0] reload_low_byte_ff;
    logic [23:0] reload_value;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reload_upper_byte_ff <= `WD_RST_UPPER;
            reload_high_byte_ff <= `WD_RST_HIGH;
            reload_low_byte_ff <= `WD_RST_LOW;
        end else begin
            if (reload_wr.upper) begin
                reload_upper_byte_ff <= reg_wdata;
            end
            if (reload_wr.high) begin
                reload_high_byte_ff <= reg_wdata;
            end
            if (reload_wr.low) begin
                reload_low_byte_ff <= reg_wdata;
            end
        end
    end

    assign reload_value = {reload_upper_byte_ff, reload_high_byte_ff,
                           reload_low_byte_ff};

    // ============================================================
    // Enable

    logic after_reset_ff;
    logic enabled_ff;
    logic start_now;

    // Marks the first cycle after reset release, when the option is read.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            after_reset_ff <= 1'b1;
        end else begin
            after_reset_ff <= 1'b0;
        end
    end

    // The always-on option acts only in the first cycle after reset;
    // later only the refresh instruction can start the counter.
    assign start_now = ~enabled_ff &
                       (watchdog_refresh_instruction |
                        (after_reset_ff &
                         opts.always_on_option_bit));

    // No path clears the enable short of a reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enabled_ff <= 1'b0;
        end else if (start_now) begin
            enabled_ff <= 1'b1;
        end
    end

    // ============================================================
    // Down counter

    logic [23:0] count_ff;
    logic [23:0] nxt_count;
    logic refresh_ok;
    logic reload_now;
    logic timeout_now;
    logic cpu_refresh;
    logic debug_refresh;

    // Near the end a refresh would race the time-out, so it is refused.
    assign refresh_ok = count_ff > `WD_CNT_NO_REFRESH;

    // The debugger holds the counter at its reload value every cycle.
    assign debug_refresh = enabled_ff & on_chip_debugger;
    assign cpu_refresh = enabled_ff & watchdog_refresh_instruction &
                         refresh_ok;

    // A reload wins over an oscillator tick in the same cycle.
    assign reload_now = start_now | debug_refresh | cpu_refresh;

    always_comb begin
        nxt_count = count_ff;
        timeout_now = 1'b0;
        if (reload_now) begin
            nxt_count = reload_value;
        end else if (enabled_ff && osc_tick) begin
            // Nothing reloads after a time-out, so the counter wraps and
            // runs on until software refreshes it.
            if (count_ff == `WD_CNT_ZERO) begin
                nxt_count = `WD_CNT_WRAP;
            end else begin
                // One step per oscillator period gives value/10 ms.
                nxt_count = count_ff - `WD_CNT_ONE;
            end
            if (count_ff == `WD_CNT_ONE) begin
                timeout_now = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_ff <= `WD_CNT_ZERO;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ============================================================
    // Time-out response

    logic irq_req_ff;
    logic sys_reset_req_ff;
    logic stop_recovery_ff;
    logic reset_response;

    // The option bit is non-volatile, so it is read straight each cycle.
    assign reset_response = opts.timeout_response_option_bit;

    // The interrupt is raised in stop mode as well, beside the recovery.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_req_ff <= 1'b0;
        end else begin
            irq_req_ff <= timeout_now & ~reset_response;
        end
    end

    // In stop mode the recovery takes the place of the system reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sys_reset_req_ff <= 1'b0;
        end else begin
            sys_reset_req_ff <= timeout_now & ~stop_mode &
                                reset_response;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stop_recovery_ff <= 1'b0;
        end else begin
            stop_recovery_ff <= timeout_now & stop_mode;
        end
    end

    // ============================================================
    // Reset status flags

    logic timeout_flag_ff;
    logic stop_flag_ff;
    logic status_read;

    assign status_read = req.rd && req.addr == `WD_ADDR_CTRL;

    // A time-out in the same cycle as the clearing read wins, so no
    // time-out can slip past a read that races it.
    // The flags are cleared by reset as well: a watchdog-caused system
    // reset loses them unless the reset logic outside keeps a copy.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timeout_flag_ff <= 1'b0;
        end else if (timeout_now) begin
            timeout_flag_ff <= 1'b1;
        end else if (status_read) begin
            timeout_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stop_flag_ff <= 1'b0;
        end else if (timeout_now && stop_mode) begin
            stop_flag_ff <= 1'b1;
        end else if (status_read) begin
            stop_flag_ff <= 1'b0;
        end
    end

    // ============================================================
    // Read port

    // Unlock writes to the control address touch nothing here; the only
    // state behind that address is the read-only reset status.
    // The count bytes are read one at a time, so a tick between two reads
    // can tear a multi-byte value; software should read twice and compare.
    // Read data holds its last value between reads.
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] status_byte;

    // Bits other than the two flags read as zero.
    always_comb begin
        status_byte = `WD_READ_IDLE;
        status_byte[`WD_STAT_TIMEOUT_BIT] = timeout_flag_ff;
        status_byte[`WD_STAT_STOP_BIT] = stop_flag_ff;
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (req.rd) begin
            unique case (req.addr)
                `WD_ADDR_CTRL: begin
                    nxt_rdata = status_byte;
                end
                `WD_ADDR_UPPER: begin
                    nxt_rdata = count_ff[23:16];
                end
                `WD_ADDR_HIGH: begin
                    nxt_rdata = count_ff[15:8];
                end
                `WD_ADDR_LOW: begin
                    nxt_rdata = count_ff[7:0];
                end
                default: begin
                    nxt_rdata = `WD_READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= `WD_READ_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ============================================================
    // Outputs

    assign reg_rdata = rdata_ff;
    assign wdt_irq_req = irq_req_ff;
    assign wdt_sys_reset_req = sys_reset_req_ff;
    assign wdt_stop_recovery = stop_recovery_ff;
    assign wdt_enabled = enabled_ff;
    assign wdt_count = count_ff;

endmodule : watchdog_timer_24bit

`default_nettype wire

/* File: dv/rc_osc_model.sv */
// Free-running model of the watchdog RC oscillator.
`default_nettype none

module rc_osc_model #(
    parameter int HALF_NS = 125
) (
    output logic osc
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========
    // Oscillator
    // The period is scaled down from the nominal rate to keep runs short.
    // The RC oscillator runs whenever the part is powered, so it never stops.
    initial begin
        osc = 1'b0;
        #7;
        forever #(HALF_NS) osc = ~osc;
    end
endmodule : rc_osc_model

`default_nettype wire

/* File: dv/watchdog_checker_sva.sv */
// Concurrent checks on the watchdog timer ports.
`default_nettype none
`include "wdt_map.svh"

module watchdog_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic watchdog_refresh_instruction,
    input wire logic timeout_response_option_bit,
    input wire logic stop_mode,
    input wire logic on_chip_debugger,
    input wire logic wdt_irq_req,
    input wire logic wdt_sys_reset_req,
    input wire logic wdt_stop_recovery,
    input wire logic wdt_enabled,
    input wire logic [23:0] wdt_count
);
    // ========
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic zero;
    logic rfr;
    logic dbg;
    logic resp;
    assign zero = wdt_count == `WD_CNT_ZERO;
    assign rfr = watchdog_refresh_instruction;
    assign dbg = on_chip_debugger;
    assign resp = timeout_response_option_bit;

    AST_IRQ: assert property (wdt_irq_req |-> zero && !resp)
        else $error("irq cause");
    AST_RST: assert property (
        wdt_sys_reset_req |-> zero && resp && !stop_mode)
        else $error("reset cause");
    AST_REC: assert property (
        wdt_stop_recovery |-> zero && stop_mode)
        else $error("recovery cause");
    AST_FIRE: assert property (
        ($past(wdt_count) == `WD_CNT_ONE && zero && !resp)
        |-> ##[0:1] wdt_irq_req)
        else $error("missed time-out");
    AST_STEP: assert property (
        ($past(wdt_enabled) && !$past(rfr) && !$past(dbg)
            && wdt_count != $past(wdt_count))
        |-> wdt_count == $past(wdt_count) - 24'h000001)
        else $error("count step");
    AST_LATE: assert property (
        ($past(wdt_enabled) && $past(rfr) && !$past(dbg)
            && $past(wdt_count) <= `WD_CNT_NO_REFRESH)
        |-> wdt_count <= `WD_CNT_NO_REFRESH || wdt_count == `WD_CNT_WRAP)
        else $error("late refresh taken");
    AST_ON: assert property (wdt_enabled |=> wdt_enabled)
        else $error("watchdog stopped");
    AST_START: assert property (
        $rose(wdt_enabled) |-> $past(rfr) || $past(reset, 2))
        else $error("start cause");
    AST_DEBUG: assert property (
        (dbg && $past(dbg) && $past(dbg, 2) && $past(wdt_enabled, 2))
        |-> !wdt_irq_req && !wdt_sys_reset_req)
        else $error("time-out in debug");
    AST_STATUS: assert property (
        ($past(reg_rd) && $past(reg_addr) == `WD_ADDR_CTRL)
        |-> reg_rdata[5:0] == 6'h00)
        else $error("status spare bits");
    AST_COUNT: assert property (
        ($past(reg_rd) && $past(reg_addr) == `WD_ADDR_LOW)
        |-> reg_rdata == $past(wdt_count[7:0]))
        else $error("low byte read");

    cover property (wdt_irq_req && !stop_mode);
    cover property (wdt_sys_reset_req);
    cover property (wdt_stop_recovery && wdt_irq_req);
endmodule : watchdog_checker

bind watchdog_timer_24bit watchdog_checker u_checker (
    .sys_clk(sys_clk), .reset(reset), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .watchdog_refresh_instruction(watchdog_refresh_instruction),
    .timeout_response_option_bit(timeout_response_option_bit),
    .stop_mode(stop_mode), .on_chip_debugger(on_chip_debugger),
    .wdt_irq_req(wdt_irq_req), .wdt_sys_reset_req(wdt_sys_reset_req),
    .wdt_stop_recovery(wdt_stop_recovery), .wdt_enabled(wdt_enabled),
    .wdt_count(wdt_count)
);

`default_nettype wire

/* File: dv/watchdog_timer_24bit_bench.sv */
// Self-checking bench for the watchdog timer.
`default_nettype none
`include "wdt_map.svh"

module watchdog_timer_24bit_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ========
    // Signals
    localparam int PER = 10;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic refresh = 1'b0;
    logic ao = 1'b0;
    logic resp = 1'b0;
    logic stop = 1'b0;
    logic dbg = 1'b0;
    logic irq;
    logic rst_req;
    logic rec;
    logic en;
    logic [23:0] count;
    logic osc;
    logic [7:0] rd_val;
    logic [23:0] rl;
    logic [2:0] p;
    logic ok;
    int t0;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    rc_osc_model #(.HALF_NS(125)) osc_src (.osc(osc));

    watchdog_timer_24bit dut (
        .sys_clk(sys_clk), .reset(reset), .wdt_osc(osc),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .watchdog_refresh_instruction(refresh),
        .always_on_option_bit(ao), .timeout_response_option_bit(resp),
        .stop_mode(stop), .on_chip_debugger(dbg), .wdt_irq_req(irq),
        .wdt_sys_reset_req(rst_req), .wdt_stop_recovery(rec),
        .wdt_enabled(en), .wdt_count(count)
    );

    // ========
    // Helpers
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask : rd

    task automatic load_reload(input logic [23:0] v);
        wr(`WD_ADDR_CTRL, `WD_UNLOCK_FIRST);
        wr(`WD_ADDR_CTRL, `WD_UNLOCK_SECOND);
        wr(`WD_ADDR_UPPER, v[23:16]);
        wr(`WD_ADDR_HIGH, v[15:8]);
        wr(`WD_ADDR_LOW, v[7:0]);
    endtask : load_reload

    task automatic kick;
        @(negedge sys_clk);
        refresh = 1'b1;
        @(negedge sys_clk);
        refresh = 1'b0;
    endtask : kick

    // Pulses are one cycle wide, so every cycle is sampled.
    task automatic wait_pulse;
        p = 3'b000;
        for (int i = 0; i < 800 && p == 3'b000; i++) begin
            @(negedge sys_clk);
            p = {irq, rst_req, rec};
        end
    endtask : wait_pulse

    function automatic logic [2:0] pulses(input logic r, input logic s);
        return {!r, r && !s, s};
    endfunction : pulses

    function automatic logic [7:0] status(input logic s);
        return {1'b1, s, 6'h00};
    endfunction : status

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop;
        end
    end

    // ========
    // Scenarios
    initial begin
        void'($urandom(32'h92A4));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        rd(12'hFF8);
        check(rd_val, 24'h000000);
        check(en, 1'b0);
        wr(`WD_ADDR_LOW, 8'h07);
        kick;
        check(en, 1'b1);
        check(count, 24'h000400);
        wr(`WD_ADDR_CTRL, `WD_UNLOCK_FIRST);
        wr(`WD_ADDR_CTRL, `WD_UNLOCK_SECOND);
        rd(`WD_ADDR_CTRL);
        check(rd_val, 24'h000000);
        wr(12'hFF5, 8'h3C);
        wr(`WD_ADDR_UPPER, 8'h00);
        wr(`WD_ADDR_HIGH, 8'h00);
        wr(`WD_ADDR_LOW, 8'h09);
        kick;
        check(count, 24'h000400);
        for (int k = 0; k < 4; k++) begin
            rl = 24'h000004 + 24'($urandom_range(12));
            {resp, stop} = 2'(k);
            load_reload(rl);
            kick;
            t0 = cycles;
            check(count, rl);
            if (k == 0) begin
                for (int i = 0; i < 400 && count !== 24'h000002; i++) begin
                    @(negedge sys_clk);
                end
                kick;
            end
            wait_pulse;
            ok = (cycles - t0) >= PER * (int'(rl) - 2);
            ok = ok && (cycles - t0) <= PER * (int'(rl) + 1);
            check(ok, 1'b1);
            check(p, pulses(resp, stop));
            rd(`WD_ADDR_CTRL);
            check(rd_val, status(stop));
            rd(`WD_ADDR_CTRL);
            check(rd_val, 24'h000000);
            for (int i = 0; i < 40 && count === 24'h000000; i++) begin
                @(negedge sys_clk);
            end
            check(count, `WD_CNT_WRAP);
        end
        rl = 24'h000004 + 24'($urandom_range(200));
        load_reload(rl);
        kick;
        dbg = 1'b1;
        wait_pulse;
        check(p, 3'b000);
        for (int i = 0; i < 3; i++) begin
            rd(`WD_ADDR_UPPER + 12'(i));
            check(rd_val, rl[8 * (2 - i) +: 8]);
        end
        dbg = 1'b0;
        reset = 1'b1;
        ao = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(en, 1'b1);
        check(count, 24'h000400);
        report_and_stop;
    end
endmodule : watchdog_timer_24bit_bench

`default_nettype wire
